// file: logic/vbre_cfg.svh
`ifndef VBRE_CFG_SVH
`define VBRE_CFG_SVH

// data unit and timing
`define VBRE_SECT_BYTES   512
`define VBRE_SECT_SHIFT   9
`define VBRE_WORD_SHIFT   2
`define VBRE_SENSE_BYTES  96
`define VBRE_CLK_NS       50
`define VBRE_COMMIT_NS    1000
`define VBRE_COMMIT_CYC   ((`VBRE_COMMIT_NS + `VBRE_CLK_NS - 1) / `VBRE_CLK_NS)

// feature bit positions
`define VBRE_F_BARRIER    0
`define VBRE_F_SIZE_MAX   1
`define VBRE_F_SEG_MAX    2
`define VBRE_F_GEOMETRY   4
`define VBRE_F_RO         5
`define VBRE_F_BLK_SIZE   6
`define VBRE_F_SCSI       7
`define VBRE_F_FLUSH      9
`define VBRE_F_TOPOLOGY   10
`define VBRE_F_WCE        11
`define VBRE_FEAT_RST     32'h0000_0ED7

// request types and status codes
`define VBRE_T_READ       32'h0000_0000
`define VBRE_T_WRITE      32'h0000_0001
`define VBRE_T_SCSI_A     32'h0000_0002
`define VBRE_T_SCSI_B     32'h0000_0003
`define VBRE_T_FLUSH      32'h0000_0004
`define VBRE_T_FLUSH_LEG  32'h0000_0005
`define VBRE_T_BARRIER    32'h8000_0000
`define VBRE_S_OK         8'h00
`define VBRE_S_IOERR      8'h01
`define VBRE_S_UNSUPP     8'h02

// register byte offsets
`define VBRE_A_CAP_LO     8'h00
`define VBRE_A_CAP_HI     8'h04
`define VBRE_A_SEG_BYTES  8'h08
`define VBRE_A_SEG_COUNT  8'h0C
`define VBRE_A_GEOMETRY   8'h10
`define VBRE_A_BLK_BYTES  8'h14
`define VBRE_A_TOPO_LO    8'h18
`define VBRE_A_TOPO_HI    8'h1C
`define VBRE_A_CACHE      8'h20
`define VBRE_A_FEAT_OFFER 8'h40
`define VBRE_A_FEAT_NEG   8'h44
`define VBRE_A_CTRL       8'h48
`define VBRE_A_STATUS     8'h4C

// control and status fields
`define VBRE_CTRL_LEGACY  0
`define VBRE_CTRL_BE      1
`define VBRE_ST_BUSY      0
`define VBRE_ST_DIRTY     1
`define VBRE_ST_WB        2
`define VBRE_RESP_OKAY    2'b00
`define VBRE_RESP_SLVERR  2'b10

`endif

// file: logic/vbre_pkg.sv
package vbre_pkg;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_DECODE = 6'b00_0010,
    ST_WRITE  = 6'b00_0100,
    ST_READ   = 6'b00_1000,
    ST_COMMIT = 6'b01_0000,
    ST_DONE   = 6'b10_0000
  } vbre_state_e;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_READ  = 3'h1,
    OP_WRITE = 3'h2,
    OP_FLUSH = 3'h3,
    OP_SCSI  = 3'h4
  } vbre_op_e;

endpackage

// file: logic/vbre_bswap.sv
`timescale 1ns/1ps
module vbre_bswap #(
  parameter int NB = 4,
  parameter int NL = 1
) (
  input  wire logic              en,
  input  wire logic [NB*NL*8-1:0] din,
  output logic      [NB*NL*8-1:0] dout
);
  // reverses bytes inside each lane of NB bytes when en is set
  genvar l;
  genvar b;
  generate
    for (l = 0; l < NL; l++)
    begin : g_lane
      for (b = 0; b < NB; b++)
      begin : g_byte
        assign dout[(l*NB+b)*8 +: 8] = en ? din[(l*NB+NB-1-b)*8 +: 8] : din[(l*NB+b)*8 +: 8];
      end
    end
  endgenerate
endmodule

// file: logic/vbre_store.sv
`timescale 1ns/1ps
module vbre_store #(
  parameter int WORDS = 512,
  parameter int AW    = 9
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  // flip-flop backing store; contents are data, not control, so no reset
  logic [31:0] mem [WORDS];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// file: logic/vbre_engine.sv
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "vbre_cfg.svh"
module vbre_engine #(
  parameter int          DISK_SECTORS = 4,
  parameter logic [31:0] SEG_BYTES    = 32'h0000_1000,
  parameter logic [31:0] SEG_COUNT    = 32'h0000_0008,
  parameter logic [15:0] CYLINDERS    = 16'h0001,
  parameter logic [7:0]  HEADS        = 8'h01,
  parameter logic [7:0]  TRACK_SECTS  = 8'h04,
  parameter logic [31:0] BLK_BYTES    = 32'h0000_0200,
  parameter logic [7:0]  PHYS_LOG2    = 8'h00,
  parameter logic [7:0]  ALIGN_BLK    = 8'h00,
  parameter logic [15:0] MIN_IO       = 16'h0001,
  parameter logic [31:0] OPT_IO       = 32'h0000_0001
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [31:0] REQ_TYPE,
  input  wire logic [63:0] REQ_SECTOR,
  input  wire logic [15:0] REQ_NSECT,
  input  wire logic [15:0] REQ_TAG,
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  input  wire logic [31:0] WR_DATA,
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic [31:0]      RD_DATA,
  output logic             CPL_VALID,
  input  wire logic        CPL_READY,
  output logic [15:0]      CPL_TAG,
  output logic [7:0]       CPL_STATUS,
  output logic [31:0]      CPL_SENSE_LEN,
  output logic [31:0]      CPL_RESIDUAL
);
  import vbre_pkg::*;

  localparam int          SECT_WORDS = `VBRE_SECT_BYTES / 4;
  localparam int          WORDS      = DISK_SECTORS * SECT_WORDS;
  localparam int          AW         = $clog2(WORDS);
  localparam int          CW         = 16 + $clog2(SECT_WORDS);
  localparam logic [15:0] COMMIT_CYC = 16'(`VBRE_COMMIT_CYC);
  localparam logic [64:0] DISK_END   = 65'(DISK_SECTORS);

  vbre_state_e state_r;
  logic [31:0] feat_offer_r;
  logic [31:0] feat_neg_r;
  logic [1:0]  ctrl_r;
  logic        cache_mode_r;
  logic        cache_set_r;
  logic        dirty_r;
  logic [7:0]  last_status_r;
  logic [31:0] type_r;
  logic [63:0] sector_r;
  logic [15:0] nsect_r;
  logic [15:0] tag_r;
  logic [7:0]  sts_r;
  logic [CW-1:0] widx_r;
  logic [AW-1:0] addr_r;
  logic [31:0] rdat_r;
  logic        rvalid_r;
  logic [15:0] cnt_r;
  logic [31:0] sense_len_r;
  logic [31:0] residual_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_bus_r;
  logic [31:0] rdata_bus_r;
  logic [1:0]  rresp_r;

  logic        legacy;
  logic        swap;
  logic        cache_wb;
  logic [31:0] wmask;
  logic        wr_fire;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [63:0] cap_img;
  logic [127:0] cfg32_img;
  logic [31:0] cyl_min_img;
  logic [31:0] type_sw;
  logic [63:0] sector_sw;
  logic [72:0] byte_off;
  logic [CW-1:0] last_idx;
  logic        xfer_last;
  logic        wr_take;
  logic        rd_take;
  logic        store_we;
  logic [31:0] store_rdata;
  logic [31:0] base_type;
  logic [64:0] req_end;
  logic        range_bad;
  vbre_op_e    dec_op;
  logic [7:0]  dec_sts;

  assign legacy   = ctrl_r[`VBRE_CTRL_LEGACY];
  assign swap     = legacy & ctrl_r[`VBRE_CTRL_BE];
  // toggle only counts once software has chosen a mode; until then follow flush
  assign cache_wb = (legacy & feat_offer_r[`VBRE_F_WCE] & cache_set_r) ? cache_mode_r
                  : feat_neg_r[`VBRE_F_FLUSH];

  // ---------------- register bus ----------------
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_wmask
      assign wmask[gb*8 +: 8] = {8{wstrb_r[gb]}};
    end
  endgenerate

  assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = ~rvalid_bus_r;
  assign S_AXI_RVALID  = rvalid_bus_r;
  assign S_AXI_RDATA   = rdata_bus_r;
  assign S_AXI_RRESP   = rresp_r;
  assign wr_fire       = aw_hold_r & w_hold_r & ~bvalid_r;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `VBRE_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold_r <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb_r  <= S_AXI_WSTRB;
      end
      if (wr_fire)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        // config words are read-only but answer okay; only holes are errors
        bresp_r   <= (awaddr_r > `VBRE_A_STATUS || awaddr_r[1:0] != 2'b00 ||
                     (awaddr_r > `VBRE_A_CACHE && awaddr_r < `VBRE_A_FEAT_OFFER))
                   ? `VBRE_RESP_SLVERR : `VBRE_RESP_OKAY;
      end
      else if (bvalid_r && S_AXI_BREADY)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software-steered registers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      feat_offer_r <= `VBRE_FEAT_RST;
      feat_neg_r   <= 32'h0000_0000;
      ctrl_r       <= 2'b00;
      cache_mode_r <= 1'b0;
      cache_set_r  <= 1'b0;
    end
    else if (wr_fire)
    begin
      case (awaddr_r)
        `VBRE_A_FEAT_OFFER: feat_offer_r <= (feat_offer_r & ~wmask) | (wdata_r & wmask);
        `VBRE_A_FEAT_NEG:   feat_neg_r <= (feat_neg_r & ~wmask) | (wdata_r & wmask);
        `VBRE_A_CTRL:       ctrl_r <= (ctrl_r & ~wmask[1:0]) | (wdata_r[1:0] & wmask[1:0]);
        `VBRE_A_CACHE:
        begin
          if (legacy && feat_offer_r[`VBRE_F_WCE] && wstrb_r[0])
          begin
            cache_mode_r <= wdata_r[0];
            cache_set_r  <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // config image, byte order per field width
  vbre_bswap #(.NB(8), .NL(1)) u_sw_cap (
    .en   (swap),
    .din  (64'(DISK_SECTORS)),
    .dout (cap_img)
  );
  vbre_bswap #(.NB(4), .NL(4)) u_sw_cfg32 (
    .en   (swap),
    .din  ({OPT_IO, BLK_BYTES, SEG_COUNT, SEG_BYTES}),
    .dout (cfg32_img)
  );
  vbre_bswap #(.NB(2), .NL(2)) u_sw_cfg16 (
    .en   (swap),
    .din  ({MIN_IO, CYLINDERS}),
    .dout (cyl_min_img)
  );

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      `VBRE_A_CAP_LO:     rd_word = cap_img[31:0];
      `VBRE_A_CAP_HI:     rd_word = cap_img[63:32];
      `VBRE_A_SEG_BYTES:  rd_word = feat_offer_r[`VBRE_F_SIZE_MAX] ? cfg32_img[31:0] : '0;
      `VBRE_A_SEG_COUNT:  rd_word = feat_offer_r[`VBRE_F_SEG_MAX] ? cfg32_img[63:32] : '0;
      `VBRE_A_GEOMETRY:   rd_word = feat_offer_r[`VBRE_F_GEOMETRY]
                                  ? {TRACK_SECTS, HEADS, cyl_min_img[15:0]} : '0;
      `VBRE_A_BLK_BYTES:  rd_word = feat_offer_r[`VBRE_F_BLK_SIZE] ? cfg32_img[95:64] : '0;
      `VBRE_A_TOPO_LO:    rd_word = feat_offer_r[`VBRE_F_TOPOLOGY]
                                  ? {cyl_min_img[31:16], ALIGN_BLK, PHYS_LOG2} : '0;
      `VBRE_A_TOPO_HI:    rd_word = feat_offer_r[`VBRE_F_TOPOLOGY] ? cfg32_img[127:96] : '0;
      `VBRE_A_CACHE:      rd_word = {31'h0000_0000, cache_wb};
      `VBRE_A_FEAT_OFFER: rd_word = feat_offer_r;
      `VBRE_A_FEAT_NEG:   rd_word = feat_neg_r;
      `VBRE_A_CTRL:       rd_word = {30'h0000_0000, ctrl_r};
      `VBRE_A_STATUS:     rd_word = {16'h0000, last_status_r, 5'h00, cache_wb, dirty_r,
                                     (state_r != ST_IDLE)};
      default:            rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_bus_r <= 1'b0;
      rdata_bus_r  <= 32'h0000_0000;
      rresp_r      <= `VBRE_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_bus_r <= 1'b1;
      rdata_bus_r  <= rd_word;
      rresp_r      <= rd_hit ? `VBRE_RESP_OKAY : `VBRE_RESP_SLVERR;
    end
    else if (rvalid_bus_r && S_AXI_RREADY)
    begin
      rvalid_bus_r <= 1'b0;
    end
  end

  // ---------------- request engine ----------------
  vbre_bswap #(.NB(4), .NL(1)) u_sw_type (
    .en   (swap),
    .din  (REQ_TYPE),
    .dout (type_sw)
  );
  vbre_bswap #(.NB(8), .NL(1)) u_sw_sector (
    .en   (swap),
    .din  (REQ_SECTOR),
    .dout (sector_sw)
  );

  // requests run one at a time, so a barrier never overtakes or is overtaken
  assign base_type = (legacy && feat_neg_r[`VBRE_F_BARRIER] && feat_offer_r[`VBRE_F_BARRIER])
                   ? (type_r & ~`VBRE_T_BARRIER) : type_r;
  assign req_end   = {1'b0, sector_r} + 65'(nsect_r);
  assign range_bad = req_end > DISK_END;
  assign byte_off  = {sector_r, {`VBRE_SECT_SHIFT{1'b0}}};
  assign last_idx  = CW'({nsect_r, {$clog2(SECT_WORDS){1'b0}}} - 1);

  always_comb
  begin
    dec_op  = OP_NONE;
    dec_sts = `VBRE_S_UNSUPP;
    case (base_type)
      `VBRE_T_READ:
      begin
        dec_op  = OP_READ;
        dec_sts = range_bad ? `VBRE_S_IOERR : `VBRE_S_OK;
      end
      `VBRE_T_WRITE:
      begin
        dec_op  = OP_WRITE;
        dec_sts = (range_bad || feat_offer_r[`VBRE_F_RO]) ? `VBRE_S_IOERR : `VBRE_S_OK;
      end
      `VBRE_T_FLUSH:
      begin
        dec_op  = OP_FLUSH;
        dec_sts = `VBRE_S_OK;
      end
      `VBRE_T_FLUSH_LEG:
      begin
        if (legacy)
        begin
          dec_op  = OP_FLUSH;
          dec_sts = `VBRE_S_OK;
        end
      end
      `VBRE_T_SCSI_A, `VBRE_T_SCSI_B:
      begin
        // no target behind the store: accepted but always fails
        if (legacy && feat_offer_r[`VBRE_F_SCSI] && feat_neg_r[`VBRE_F_SCSI])
        begin
          dec_op  = OP_SCSI;
          dec_sts = `VBRE_S_IOERR;
        end
      end
      default: ;
    endcase
  end

  assign xfer_last = (widx_r == last_idx);
  assign wr_take   = (state_r == ST_WRITE) && WR_VALID;
  assign rd_take   = (state_r == ST_READ) && rvalid_r && RD_READY;
  assign store_we  = wr_take && (sts_r == `VBRE_S_OK);

  vbre_store #(.WORDS(WORDS), .AW(AW)) u_store (
    .clk   (CLK),
    .we    (store_we),
    .waddr (addr_r),
    .wdata (WR_DATA),
    .raddr (addr_r),
    .rdata (store_rdata)
  );

  assign REQ_READY     = (state_r == ST_IDLE);
  assign WR_READY      = (state_r == ST_WRITE);
  assign RD_VALID      = rvalid_r;
  assign RD_DATA       = rdat_r;
  assign CPL_VALID     = (state_r == ST_DONE);
  assign CPL_TAG       = tag_r;
  assign CPL_STATUS    = sts_r;
  assign CPL_SENSE_LEN = sense_len_r;
  assign CPL_RESIDUAL  = residual_r;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r       <= ST_IDLE;
      type_r        <= 32'h0000_0000;
      sector_r      <= 64'h0000_0000_0000_0000;
      nsect_r       <= 16'h0000;
      tag_r         <= 16'h0000;
      sts_r         <= `VBRE_S_OK;
      widx_r        <= '0;
      addr_r        <= '0;
      rdat_r        <= 32'h0000_0000;
      rvalid_r      <= 1'b0;
      cnt_r         <= 16'h0000;
      sense_len_r   <= 32'h0000_0000;
      residual_r    <= 32'h0000_0000;
      last_status_r <= `VBRE_S_OK;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (REQ_VALID)
          begin
            type_r   <= type_sw;
            sector_r <= sector_sw;
            nsect_r  <= REQ_NSECT;
            tag_r    <= REQ_TAG;
            state_r  <= ST_DECODE;
          end
        end
        ST_DECODE:
        begin
          sts_r       <= dec_sts;
          widx_r      <= '0;
          addr_r      <= byte_off[AW+`VBRE_WORD_SHIFT-1:`VBRE_WORD_SHIFT];
          cnt_r       <= 16'h0000;
          rvalid_r    <= 1'b0;
          sense_len_r <= 32'h0000_0000;
          // nothing moves for scsi, so the whole data length is residual
          residual_r  <= (dec_op == OP_SCSI)
                       ? 32'({nsect_r, {`VBRE_SECT_SHIFT{1'b0}}}) : 32'h0000_0000;
          if (dec_op == OP_WRITE && nsect_r != 16'h0000)
          begin
            state_r <= ST_WRITE; // failed writes still drain their data
          end
          else if (dec_op == OP_READ && nsect_r != 16'h0000 && dec_sts == `VBRE_S_OK)
          begin
            state_r <= ST_READ;
          end
          else if (dec_op == OP_FLUSH && dirty_r)
          begin
            state_r <= ST_COMMIT;
          end
          else
          begin
            state_r <= ST_DONE;
          end
        end
        ST_WRITE:
        begin
          if (wr_take)
          begin
            widx_r <= widx_r + 1'b1;
            addr_r <= addr_r + 1'b1;
            if (xfer_last)
            begin
              state_r <= (sts_r == `VBRE_S_OK && !cache_wb) ? ST_COMMIT : ST_DONE;
            end
          end
        end
        ST_READ:
        begin
          if (!rvalid_r)
          begin
            rdat_r   <= store_rdata;
            rvalid_r <= 1'b1;
          end
          else if (rd_take)
          begin
            rvalid_r <= 1'b0;
            widx_r   <= widx_r + 1'b1;
            addr_r   <= addr_r + 1'b1;
            if (xfer_last)
            begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_COMMIT:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == COMMIT_CYC - 1'b1)
          begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          if (CPL_READY)
          begin
            last_status_r <= sts_r;
            state_r       <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // unwritten-back data; a commit drains everything, earlier writes included
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dirty_r <= 1'b0;
    end
    else if (wr_take && xfer_last && sts_r == `VBRE_S_OK && cache_wb)
    begin
      dirty_r <= 1'b1;
    end
    else if (state_r == ST_COMMIT && cnt_r == COMMIT_CYC - 1'b1)
    begin
      dirty_r <= 1'b0;
    end
  end
endmodule

// file: tb/vbre_chk_assertions.sv
`timescale 1ns/1ps
module vbre_chk (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        REQ_VALID,
  input wire logic        REQ_READY,
  input wire logic        RD_VALID,
  input wire logic        WR_READY,
  input wire logic        CPL_VALID,
  input wire logic        CPL_READY,
  input wire logic [7:0]  CPL_STATUS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence take_s; REQ_VALID && REQ_READY; endsequence
  sequence busy_s; !REQ_READY [*2]; endsequence
  sequence cpl_wait_s; CPL_VALID && !CPL_READY; endsequence
  req_busy_a: assert property (take_s |=> busy_s)
    else $error("request port open while busy");
  cpl_hold_a: assert property (cpl_wait_s |=> CPL_VALID && $stable(CPL_STATUS))
    else $error("completion dropped or changed");
  cpl_code_a: assert property (CPL_VALID |-> CPL_STATUS <= 8'h02)
    else $error("illegal status code");
  cpl_quiet_a: assert property (CPL_VALID |-> !RD_VALID && !WR_READY)
    else $error("data moving after status");
  done_idle_a: assert property (CPL_VALID && CPL_READY |=> REQ_READY)
    else $error("no return to idle");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
endmodule

// file: tb/vbre_guest.sv
`timescale 1ns/1ps
module vbre_guest (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_READY,
  input  wire logic        WR_READY,
  input  wire logic        RD_VALID,
  input  wire logic [31:0] RD_DATA,
  input  wire logic [31:0] seed,
  input  wire logic        slow,
  output logic             WR_VALID,
  output logic [31:0]      WR_DATA,
  output logic             RD_READY,
  output logic [15:0]      rd_cnt,
  output logic [15:0]      rd_bad
);
  logic [15:0] idx_r;
  logic        tick_r;
  // data word k of a request is seed plus k, so reads are checked without a copy
  assign WR_VALID = 1'b1;
  assign WR_DATA  = seed + {16'h0000, idx_r};
  assign RD_READY = !slow || tick_r;
  assign rd_cnt   = idx_r;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      idx_r <= '0;
    else if (REQ_VALID && REQ_READY)
      idx_r <= '0;
    else if ((WR_VALID && WR_READY) || (RD_VALID && RD_READY))
      idx_r <= idx_r + 16'h0001;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      rd_bad <= '0;
    else if (REQ_VALID && REQ_READY)
      rd_bad <= '0;
    else if (RD_VALID && RD_READY && RD_DATA !== WR_DATA)
      rd_bad <= rd_bad + 16'h0001;
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      tick_r <= 1'b0;
    else
      tick_r <= !tick_r;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        CLK = 1'b0, RSTN = 1'b0, slow = 1'b0;
  logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, CPL_STATUS;
  logic [31:0] S_AXI_WDATA = '0, REQ_TYPE = '0, seed = '0;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, REQ_VALID = 1'b0, CPL_READY = 1'b0;
  logic [63:0] REQ_SECTOR = '0;
  logic [15:0] REQ_NSECT = '0, REQ_TAG = '0, rd_cnt, rd_bad, CPL_TAG;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        REQ_READY, WR_VALID, WR_READY, RD_VALID, RD_READY, CPL_VALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA, WR_DATA, RD_DATA, CPL_SENSE_LEN, CPL_RESIDUAL;
  int          err_total = 0, n_tests = 0, cyc = 0;
  vbre_engine u_dut (.*);
  vbre_guest u_guest (.*);
  always #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      results();
    end
  end
  task automatic results();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (aw || w)
    begin
      @(posedge CLK);
      if (aw && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (w && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      aw = aw && !S_AXI_AWREADY;
      w = w && !S_AXI_WREADY;
    end
    while (!S_AXI_BVALID) @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
    chk({30'h0, S_AXI_BRESP}, 32'h0000_0000);
    @(posedge CLK);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    if (er == 2'b00) chk(S_AXI_RDATA, d);
    chk({30'h0, S_AXI_RRESP}, {30'h0, er});
    @(posedge CLK);
  endtask
  // completion fields are taken at the handshake edge, before the design moves on
  task automatic req(input logic [31:0] t, input logic [63:0] s, input logic [15:0] n,
                     input logic [7:0] st);
    REQ_TYPE <= t;
    REQ_SECTOR <= s;
    REQ_NSECT <= n;
    REQ_TAG <= t[15:0] ^ 16'h5A00;
    REQ_VALID <= 1'b1;
    do @(posedge CLK); while (!REQ_READY);
    REQ_VALID <= 1'b0;
    do @(posedge CLK); while (!CPL_VALID);
    // one cycle of back-pressure, so the completion has to hold
    CPL_READY <= 1'b1;
    @(posedge CLK);
    CPL_READY <= 1'b0;
    chk({24'h0, CPL_STATUS}, {24'h0, st});
    chk({16'h0, CPL_TAG}, {16'h0, t[15:0] ^ 16'h5A00});
  endtask
  task automatic s_regs();
    axi_rd(8'h00, 32'h0000_0004, 2'b00);
    axi_rd(8'h04, 32'h0000_0000, 2'b00);
    axi_rd(8'h08, 32'h0000_1000, 2'b00);
    axi_rd(8'h0C, 32'h0000_0008, 2'b00);
    axi_rd(8'h10, 32'h0401_0001, 2'b00);
    axi_rd(8'h14, 32'h0000_0200, 2'b00);
    axi_rd(8'h18, 32'h0001_0000, 2'b00);
    axi_rd(8'h1C, 32'h0000_0001, 2'b00);
    axi_rd(8'h30, 32'h0000_0000, 2'b10);
    axi_wr(8'h00, 32'h0000_FFFF);
    axi_rd(8'h00, 32'h0000_0004, 2'b00);
  endtask
  task automatic s_rw();
    seed <= 32'hB000_0000;
    req(32'h0000_0001, 64'h0, 16'h0001, 8'h00);
    seed <= 32'hA000_0000;
    req(32'h0000_0001, 64'h1, 16'h0001, 8'h00);
    slow <= 1'b1;
    req(32'h0000_0000, 64'h1, 16'h0001, 8'h00);
    chk({16'h0, rd_cnt}, 32'h0000_0080);
    chk({16'h0, rd_bad}, 32'h0000_0000);
  endtask
  task automatic s_ro();
    axi_wr(8'h40, 32'h0000_0EF7);
    seed <= 32'hC000_0000;
    req(32'h0000_0001, 64'h1, 16'h0001, 8'h01);
    seed <= 32'hA000_0000;
    req(32'h0000_0000, 64'h1, 16'h0001, 8'h00);
    chk({16'h0, rd_bad}, 32'h0000_0000);
    axi_wr(8'h40, 32'h0000_0ED7);
  endtask
  task automatic s_types();
    req(32'h0000_0004, 64'h0, 16'h0000, 8'h00);
    req(32'h0000_0007, 64'h0, 16'h0000, 8'h02);
    axi_wr(8'h48, 32'h0000_0001);
    axi_wr(8'h44, 32'h0000_0081);
    axi_wr(8'h48, 32'h0000_0003);
    axi_rd(8'h04, 32'h0400_0000, 2'b00);
    req(32'h0400_0000, 64'h0, 16'h0000, 8'h00);
    axi_wr(8'h48, 32'h0000_0001);
    req(32'h0000_0005, 64'h0, 16'h0000, 8'h00);
    for (int k = 2; k < 4; k++)
    begin
      req(k, 64'h0, 16'h0001, 8'h01);
      chk(CPL_RESIDUAL, 32'h0000_0200);
      chk(CPL_SENSE_LEN, 32'h0000_0000);
    end
    req(32'h8000_0000, 64'h1, 16'h0001, 8'h00);
    chk({16'h0, rd_bad}, 32'h0000_0000);
  endtask
  // flush negotiated: writeback, a write leaves dirty data until a flush commits it
  task automatic s_cache();
    axi_wr(8'h44, 32'h0000_0281);
    axi_rd(8'h20, 32'h0000_0001, 2'b00);
    req(32'h0000_0001, 64'h2, 16'h0001, 8'h00);
    axi_rd(8'h4C, 32'h0000_0006, 2'b00);
    req(32'h0000_0004, 64'h0, 16'h0000, 8'h00);
    axi_rd(8'h4C, 32'h0000_0004, 2'b00);
    axi_wr(8'h20, 32'h0000_0000);
    axi_rd(8'h20, 32'h0000_0000, 2'b00);
  endtask
  initial
  begin
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    s_regs();
    s_rw();
    s_ro();
    s_types();
    s_cache();
    results();
  end
endmodule
bind vbre_engine vbre_chk u_chk (.*);
